/* File: rng_core.sv */
// Ring oscillator random number generator with FIFO and two bus ports.
// Assumes an async oscillator bit on a pin and AHB-lite / APB masters on sys_clk_in.
`timescale 1ns/100ps
module rng_core
   import rng_pkg::*;
(
   input wire logic sys_clk_in, // 10 MHz clock
   input wire logic rst_b_in, // Async reset, active low
   input wire logic ring_osc_bit_in, // Raw oscillator bit, async
   output logic osc_enable_out, // Oscillator run enable
   input wire logic hsel_in, // AHB select
   input wire logic [31:0] haddr_in, // AHB address
   input wire logic [1:0] htrans_in, // AHB transfer type
   input wire logic hwrite_in, // AHB write
   input wire logic hready_in, // AHB bus ready
   output logic [31:0] hrdata_out, // AHB read data
   output logic hreadyout_out, // AHB slave ready
   output logic hresp_out, // AHB response
   input wire logic psel_in, // APB select
   input wire logic penable_in, // APB enable
   input wire logic pwrite_in, // APB write
   input wire logic [rng_pkg::APB_AW-1:0] paddr_in, // APB address
   input wire logic [31:0] pwdata_in, // APB write data
   output logic [31:0] prdata_out, // APB read data
   output logic pready_out, // APB ready
   output logic pslverr_out, // APB error
   output logic rng_interrupt_out // Data available interrupt
);
   // =====================================
   // Helpers

   // APB address match to one offset
   function automatic logic apb_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] o);
      apb_hit = (a == o);
   endfunction

   // =====================================
   // Declarations
   logic osc_meta; // First sync stage
   logic osc_sync; // Second sync stage
   logic generation_enable; // Control bit
   logic entropy_source_select; // Control bit
   logic rng_clock_gate; // Clock control bit
   logic next_generation_enable;
   logic next_entropy_source_select;
   logic next_rng_clock_gate;
   logic [31:0] lfsr; // Pseudo random source
   logic [31:0] next_lfsr;
   logic [31:0] shreg; // Whitening shift register
   logic [31:0] next_shreg;
   logic [8:0] cyc_cnt; // Cycles into current word
   logic [8:0] next_cyc_cnt;
   logic word_done; // Word ready for buffer
   logic run; // Generation running
   logic ent_bit; // Selected entropy bit
   logic [31:0] buf0; // Buffer head
   logic [31:0] buf1; // Buffer tail
   logic [1:0] buf_cnt; // Buffer entries
   logic [31:0] next_buf0;
   logic [31:0] next_buf1;
   logic [1:0] next_buf_cnt;
   logic buf_in_ready; // Buffer accepts a word
   logic buf_out_valid; // Buffer holds a word
   logic buf_out_ready; // FIFO accepts a word
   logic [31:0] fifo_mem [FIFO_DEPTH]; // Word storage
   logic [PTR_W-1:0] wr_ptr; // Write pointer
   logic [PTR_W-1:0] rd_ptr; // Read pointer
   logic [LVL_W-1:0] fill; // Words held
   logic [PTR_W-1:0] next_wr_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [LVL_W-1:0] next_fill;
   logic fifo_full; // FIFO at depth
   logic push; // Word into FIFO
   logic pop; // Word out of FIFO
   logic ahb_rd; // Valid read of random port
   logic [31:0] hrdata; // Read data register
   logic [31:0] next_hrdata;
   logic [31:0] prdata; // APB data register
   logic [31:0] next_prdata;
   logic irq; // Interrupt register
   logic next_irq;

   // =====================================
   // Oscillator input synchroniser

   // Two flops before any use
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
      end else begin
         osc_meta <= ring_osc_bit_in;
         osc_sync <= osc_meta;
      end
   end

   // =====================================
   // Control registers

   // APB writes; enable refused while full
   always_comb begin
      next_generation_enable = generation_enable;
      next_entropy_source_select = entropy_source_select;
      next_rng_clock_gate = rng_clock_gate;
      if (psel_in && penable_in && pwrite_in) begin
         if (apb_hit(paddr_in, RNG_CONTROL_REGISTER)) begin
            // Setting ignored when FIFO already full
            next_generation_enable = pwdata_in[GENERATION_ENABLE_BIT] && !fifo_full;
            next_entropy_source_select = pwdata_in[ENTROPY_SOURCE_SELECT_BIT];
         end
         if (apb_hit(paddr_in, BUS_CLOCK_CONTROL_REGISTER)) begin
            next_rng_clock_gate = pwdata_in[RNG_CLOCK_GATE_BIT];
         end
      end
   end

   // APB read data from flops
   always_comb begin
      next_prdata = ZERO_WORD;
      if (psel_in && !penable_in && !pwrite_in) begin
         if (apb_hit(paddr_in, RNG_CONTROL_REGISTER)) begin
            next_prdata[GENERATION_ENABLE_BIT] = generation_enable;
            next_prdata[ENTROPY_SOURCE_SELECT_BIT] = entropy_source_select;
         end else if (apb_hit(paddr_in, FILL_LEVEL_REGISTER)) begin
            next_prdata[LVL_W-1:0] = fill;
         end else if (apb_hit(paddr_in, BUS_CLOCK_CONTROL_REGISTER)) begin
            next_prdata[RNG_CLOCK_GATE_BIT] = rng_clock_gate;
         end
      end else begin
         next_prdata = prdata; // Hold through access phase
      end
   end

   // Register the control group
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         generation_enable <= 1'b0;
         entropy_source_select <= 1'b0;
         rng_clock_gate <= 1'b0;
         prdata <= ZERO_WORD;
      end else begin
         generation_enable <= next_generation_enable;
         entropy_source_select <= next_entropy_source_select;
         rng_clock_gate <= next_rng_clock_gate;
         prdata <= next_prdata;
      end
   end

   // =====================================
   // Word generator

   // Run only enabled and with room
   assign run = generation_enable && !fifo_full;
   // Zero picks oscillators, else LFSR
   assign ent_bit = entropy_source_select ? lfsr[0] : osc_sync;
   assign word_done = run && (cyc_cnt == WORD_LAST);

   // Shift, count, and stall on full buffer
   always_comb begin
      next_lfsr = lfsr;
      next_shreg = shreg;
      next_cyc_cnt = cyc_cnt;
      if (run) begin
         next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
         if (!(word_done && !buf_in_ready)) begin
            // Whitening by folding oldest bit in
            next_shreg = {shreg[30:0], shreg[31] ^ ent_bit};
            next_cyc_cnt = cyc_cnt + 9'h001;
         end
      end
   end

   // Register the generator group
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lfsr <= LFSR_SEED;
         shreg <= ZERO_WORD;
         cyc_cnt <= 9'h000;
      end else begin
         lfsr <= next_lfsr;
         shreg <= next_shreg;
         cyc_cnt <= next_cyc_cnt;
      end
   end

   // =====================================
   // Two-entry buffer

   assign buf_in_ready = (buf_cnt != 2'h2);
   assign buf_out_valid = (buf_cnt != 2'h0);
   assign buf_out_ready = !fifo_full;

   // Accept finished word, drain head to FIFO
   always_comb begin
      next_buf0 = buf0;
      next_buf1 = buf1;
      next_buf_cnt = buf_cnt;
      if (buf_out_valid && buf_out_ready) begin
         next_buf0 = buf1;
         next_buf_cnt = next_buf_cnt - 2'h1;
      end
      if (word_done && buf_in_ready) begin
         if (next_buf_cnt == 2'h0) begin
            next_buf0 = shreg;
         end else begin
            next_buf1 = shreg;
         end
         next_buf_cnt = next_buf_cnt + 2'h1;
      end
   end

   // Register the buffer group
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         buf0 <= ZERO_WORD;
         buf1 <= ZERO_WORD;
         buf_cnt <= 2'h0;
      end else begin
         buf0 <= next_buf0;
         buf1 <= next_buf1;
         buf_cnt <= next_buf_cnt;
      end
   end

   // =====================================
   // Random word FIFO

   assign fifo_full = (fill == LVL_W'(FIFO_DEPTH));
   assign push = buf_out_valid && buf_out_ready;
   // Pop at fixed address, gate set, data held
   assign ahb_rd = hsel_in && htrans_in[1] && !hwrite_in && hready_in
                   && (haddr_in == RANDOM_WORD_READ_PORT);
   assign pop = ahb_rd && rng_clock_gate && (fill != 6'h00);

   // Pointers and level
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fill = fill;
      if (push) begin
         next_wr_ptr = wr_ptr + 5'h01;
         next_fill = next_fill + 6'h01;
      end
      if (pop) begin
         next_rd_ptr = rd_ptr + 5'h01;
         next_fill = next_fill - 6'h01;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         fifo_mem[wr_ptr] <= buf0;
      end
   end

   // Register the FIFO pointers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_ptr <= 5'h00;
         rd_ptr <= 5'h00;
         fill <= 6'h00;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill <= next_fill;
      end
   end

   // =====================================
   // AHB read data and interrupt

   // Word bit 0 is byte lane 0, little-endian
   always_comb begin
      next_hrdata = ZERO_WORD;
      if (pop) begin
         next_hrdata = fifo_mem[rd_ptr];
      end
      // Level while enabled and data held, drops with the enable write
      next_irq = next_generation_enable && (next_fill != 6'h00);
   end

   // Register the answer group
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hrdata <= ZERO_WORD;
         irq <= 1'b0;
      end else begin
         hrdata <= next_hrdata;
         irq <= next_irq;
      end
   end

   // =====================================
   // Outputs
   assign osc_enable_out = run;
   assign hrdata_out = hrdata;
   assign hreadyout_out = 1'b1; // Zero wait states
   assign hresp_out = 1'b0; // Always OKAY
   assign prdata_out = prdata;
   assign pready_out = 1'b1; // No wait states
   assign pslverr_out = 1'b0; // Unmapped reads zero
   assign rng_interrupt_out = irq;
endmodule

/* File: rng_core_properties.sv */
// Port checker for the random number block.
// Assumes it is bound onto rng_core, one clock domain.
`timescale 1ns/100ps
module rng_core_props
   import rng_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic rst_b_in, // Reset, active low
   input wire logic osc_enable_out, // Oscillator run
   input wire logic hsel_in, // AHB select
   input wire logic [31:0] haddr_in, // AHB address
   input wire logic [1:0] htrans_in, // AHB transfer
   input wire logic hwrite_in, // AHB write
   input wire logic hready_in, // AHB ready in
   input wire logic [31:0] hrdata_out, // AHB data
   input wire logic hreadyout_out, // AHB ready out
   input wire logic hresp_out, // AHB response
   input wire logic psel_in, // APB select
   input wire logic penable_in, // APB enable
   input wire logic pwrite_in, // APB write
   input wire logic [rng_pkg::APB_AW-1:0] paddr_in, // APB address
   input wire logic [31:0] pwdata_in, // APB write data
   input wire logic [31:0] prdata_out, // APB read data
   input wire logic pready_out, // APB ready
   input wire logic pslverr_out, // APB error
   input wire logic rng_interrupt_out // Interrupt
);
   // ===============================
   // Shadows of the last written enable and gate
   logic en_q, next_en, gate_q, next_gate, wr, rd, pop;
   assign wr = psel_in && penable_in && pwrite_in;
   assign rd = psel_in && penable_in && !pwrite_in;
   assign pop = hsel_in && htrans_in[1] && !hwrite_in && hready_in && haddr_in == RANDOM_WORD_READ_PORT;
   // Next shadow values from APB writes
   always_comb begin
      next_en = en_q;
      next_gate = gate_q;
      if (wr && paddr_in == RNG_CONTROL_REGISTER) next_en = pwdata_in[0];
      if (wr && paddr_in == BUS_CLOCK_CONTROL_REGISTER) next_gate = pwdata_in[0];
   end
   // Shadow registers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         en_q <= 1'b0;
         gate_q <= 1'b0;
      end else begin
         en_q <= next_en;
         gate_q <= next_gate;
      end
   end
   // ===============================
   // Properties
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   ahb_okay_a: assert property (hreadyout_out && !hresp_out)
      else $error("AHB port not ready or not okay");
   apb_okay_a: assert property (pready_out && !pslverr_out)
      else $error("APB port not ready or not okay");
   no_pop_zero_a: assert property (!pop |=> hrdata_out == 32'h0)
      else $error("AHB data without a pop");
   gate_closed_a: assert property (pop && !gate_q |=> hrdata_out == 32'h0)
      else $error("Pop served with clock gate off");
   osc_needs_en_a: assert property (osc_enable_out |-> en_q)
      else $error("Oscillators run without enable");
   stop_osc_a: assert property (wr && paddr_in == RNG_CONTROL_REGISTER && !pwdata_in[0] |=> !osc_enable_out[*2])
      else $error("Oscillators still run after disable");
   irq_needs_en_a: assert property (rng_interrupt_out |-> en_q)
      else $error("Interrupt without enable");
   fill_range_a: assert property (rd && paddr_in == FILL_LEVEL_REGISTER |-> prdata_out <= 32'h20)
      else $error("Fill level out of range");
   unmapped_zero_a: assert property (rd && paddr_in > BUS_CLOCK_CONTROL_REGISTER |-> prdata_out == 32'h0)
      else $error("Unmapped register read not zero");
endmodule
bind rng_core rng_core_props chk (.*);

/* File: rng_core_test.sv */
// Self-checking bench for the random number block.
// Assumes rng_core, rng_osc_model and the port checker are compiled first.
`timescale 1ns/100ps
module rng_core_test;
   import rng_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic osc_bit, osc_en, irq, hreadyout, hresp, pready, pslverr;
   logic [1:0] htrans = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] haddr = 32'h0, pwdata = 32'h0, hrdata, prdata, d, w;
   int error_cnt = 0, check_count = 0, n;
   always #50 clk = ~clk;
   rng_osc_model osc (.clk_in(clk), .run_in(osc_en), .bit_out(osc_bit));
   rng_core dut (.sys_clk_in(clk), .rst_b_in(rst_b), .ring_osc_bit_in(osc_bit), .osc_enable_out(osc_en),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(1'b0), .hready_in(1'b1),
      .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rng_interrupt_out(irq));
   // ===============================
   // Shared tasks
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer, setup then access
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let outputs launched by the access edge settle before checks
      @(negedge clk);
   endtask
   // One AHB read, data taken in the data phase
   task automatic pop(output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= RANDOM_WORD_READ_PORT;
      @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      #1 rd = hrdata;
   endtask
   // Poll the fill level under a bound, n counts polls
   task automatic wait_fill(input logic [31:0] lvl);
      n = 0;
      d = 32'h0;
      while (d !== lvl && n < 7000) begin
         apb(1'b0, FILL_LEVEL_REGISTER, 32'h0, d);
         n++;
      end
      if (d !== lvl) begin
         error_cnt++;
         $display("[ERR] fill wait expected %h seen %h", lvl, d);
         give_verdict();
      end
   endtask
   // ===============================
   // Scenarios
   task automatic t_reset;
      apb(1'b0, RNG_CONTROL_REGISTER, 32'h0, d);
      check("control", 32'h0, d);
      apb(1'b0, FILL_LEVEL_REGISTER, 32'h0, d);
      check("fill", 32'h0, d);
      apb(1'b0, 12'h00C, 32'h0, d);
      check("unmapped", 32'h0, d);
      check("irq idle", 32'h0, {31'h0, irq});
      $display("reset values done");
   endtask
   task automatic t_first;
      apb(1'b1, BUS_CLOCK_CONTROL_REGISTER, 32'h1, d);
      apb(1'b1, RNG_CONTROL_REGISTER, 32'h1, d);
      wait_fill(32'h1);
      check("first word time", 32'h1, {31'h0, n * 3 >= 510 && n * 3 <= 522});
      check("irq with data", 32'h1, {31'h0, irq});
      pop(d);
      apb(1'b0, FILL_LEVEL_REGISTER, 32'h0, d);
      check("fill after pop", 32'h0, d);
      check("irq empty", 32'h0, {31'h0, irq});
      $display("first word done");
   endtask
   task automatic t_gate;
      apb(1'b1, BUS_CLOCK_CONTROL_REGISTER, 32'h0, d);
      wait_fill(32'h1);
      pop(d);
      check("gated data", 32'h0, d);
      apb(1'b0, FILL_LEVEL_REGISTER, 32'h0, d);
      check("gated fill", 32'h1, d);
      $display("clock gate done");
   endtask
   task automatic t_full;
      apb(1'b1, RNG_CONTROL_REGISTER, 32'h3, d);
      apb(1'b0, RNG_CONTROL_REGISTER, 32'h0, d);
      check("source select", 32'h3, d);
      wait_fill(32'h20);
      check("osc when full", 32'h0, {31'h0, osc_en});
      apb(1'b1, RNG_CONTROL_REGISTER, 32'h0, d);
      check("irq disabled", 32'h0, {31'h0, irq});
      apb(1'b1, RNG_CONTROL_REGISTER, 32'h1, d);
      apb(1'b0, RNG_CONTROL_REGISTER, 32'h0, d);
      check("enable refused", 32'h0, d & 32'h1);
      apb(1'b1, BUS_CLOCK_CONTROL_REGISTER, 32'h1, d);
      pop(w);
      pop(d);
      check("words differ", 32'h1, {31'h0, w !== d});
      for (int i = 0; i < 30; i++) pop(d);
      apb(1'b0, FILL_LEVEL_REGISTER, 32'h0, d);
      check("drained", 32'h0, d);
      pop(d);
      check("empty read", 32'h0, d);
      $display("full fifo done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_first();
      t_gate();
      t_full();
      give_verdict();
   end
endmodule

/* File: rng_osc_model.sv */
// Behavioural model of the ring oscillators feeding the random block.
// Assumes the run enable comes from the block and the clock is the system clock.
`timescale 1ns/100ps
module rng_osc_model (
   input wire logic clk_in, // System clock
   input wire logic run_in, // Rings allowed to run
   output logic bit_out // Sampled ring bit
);
   logic [6:0] ring_q = 7'h5A; // Phase of the modelled rings
   // Rings advance only while run is high, else they stand still
   always @(posedge clk_in) begin
      if (run_in) begin
         ring_q <= {ring_q[5:0], ring_q[6] ^ ring_q[5]};
      end
   end
   assign bit_out = ring_q[0];
endmodule

/* File: rng_pkg.sv */
// Constants shared by the random number block.
// Assumes one 10 MHz peripheral clock and the bus maps below.
package rng_pkg;
   // =====================================
   // Widths and depths
   localparam int WORD_W = 32; // Random word width
   localparam int FIFO_DEPTH = 32; // FIFO entries
   localparam int PTR_W = 5; // FIFO pointer width
   localparam int LVL_W = 6; // Fill level width
   localparam int APB_AW = 12; // Register address width
   // =====================================
   // Timing
   localparam int WORD_CYCLES = 512; // Clock cycles per word
   localparam logic [8:0] WORD_LAST = 9'h1FF; // Last cycle of a word
   // =====================================
   // Addresses
   localparam logic [31:0] RANDOM_WORD_READ_PORT = 32'h40040000; // FIFO pop port
   localparam logic [11:0] RNG_CONTROL_REGISTER = 12'h000; // Enable and source
   localparam logic [11:0] FILL_LEVEL_REGISTER = 12'h004; // Words held
   localparam logic [11:0] BUS_CLOCK_CONTROL_REGISTER = 12'h008; // Clock gate
   // =====================================
   // Field positions
   localparam int GENERATION_ENABLE_BIT = 0; // In control register
   localparam int ENTROPY_SOURCE_SELECT_BIT = 1; // In control register
   localparam int RNG_CLOCK_GATE_BIT = 0; // In clock control register
   // =====================================
   // Reset values and LFSR taps
   localparam logic [31:0] LFSR_SEED = 32'h0000_0001; // Pseudo source seed
   localparam logic [31:0] LFSR_TAPS = 32'h8020_0003; // Pseudo source taps
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000; // Cleared word
endpackage
